/* ctr_pkg.sv */
// Shared constants, types and helpers for the cable diagnostic result bank
package ctr_pkg;

  localparam int IDX_W = 10;
  localparam int ADDR_LSB = 2;
  localparam int RES_W = 16;
  localparam int RES_WORDS = 8;
  localparam int MEM_AW = 3;
  localparam int LOC_W = 8;
  localparam int AMP_W = 7;
  localparam int SLOT_W = 4;

  // Register indices; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_DIAG_CTRL = 10'h01e;
  localparam logic [IDX_W-1:0] IDX_TX_LOC_2_1 = 10'h180;
  localparam logic [IDX_W-1:0] IDX_TX_LOC_4_3 = 10'h181;
  localparam logic [IDX_W-1:0] IDX_RX_LOC1_TX_LOC5 = 10'h182;
  localparam logic [IDX_W-1:0] IDX_RX_PEAK_LOC_3_2 = 10'h183;
  localparam logic [IDX_W-1:0] IDX_RX_PEAK_LOC_5_4 = 10'h184;
  localparam logic [IDX_W-1:0] IDX_TX_PEAK_AMP_2_1 = 10'h185;
  localparam logic [IDX_W-1:0] IDX_TX_PEAK_AMP_4_3 = 10'h186;
  localparam logic [IDX_W-1:0] IDX_RX_AMP1_TX_AMP5 = 10'h187;

  // Control register fields
  localparam int START_BIT = 0;
  localparam int DONE_BIT = 1;
  localparam int BUSY_BIT = 2;

  localparam logic [RES_W-1:0] RESET_WORD = 16'h0000;
  localparam logic [RES_W-1:0] AMP_MASK = 16'h7f7f;
  localparam logic [MEM_AW-1:0] LOC_BASE = 3'h0;
  localparam logic [MEM_AW-1:0] AMP_BASE = 3'h5;
  localparam logic [SLOT_W-1:0] AMP_SLOTS = 4'h6;
  localparam logic [SLOT_W-1:0] RX_SLOT0 = 4'h5;
  localparam logic [2:0] PEAK_FIRST = 3'h1;
  localparam logic [2:0] PEAK_LAST = 3'h5;

  localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
  localparam int HTRANS_ACTIVE_BIT = 1;
  localparam logic HRESP_OKAY = 1'b0;

  // One reflection peak reported by the diagnostic engine
  typedef struct packed {
    logic rx_pair;
    logic [2:0] peak;
    logic [LOC_W-1:0] loc;
    logic [AMP_W-1:0] amp;
  } ctr_peak_s;

  // Bus access as seen after address decode
  typedef struct packed {
    logic valid;
    logic write;
    logic [IDX_W-1:0] idx;
  } ctr_acc_s;

  function automatic logic ctr_in_results(input logic [IDX_W-1:0] idx);
    return (idx >= IDX_TX_LOC_2_1) && (idx <= IDX_RX_AMP1_TX_AMP5);
  endfunction

  function automatic logic [MEM_AW-1:0] ctr_mem_addr(
      input logic [IDX_W-1:0] idx);
    logic [IDX_W-1:0] off;
    off = idx - IDX_TX_LOC_2_1;
    return off[MEM_AW-1:0];
  endfunction

  // Slot 0..4 transmit peaks 1..5, slot 5..9 receive peaks 1..5
  function automatic logic [SLOT_W-1:0] ctr_slot(input ctr_peak_s p);
    logic [SLOT_W-1:0] base;
    base = p.rx_pair ? RX_SLOT0 : 4'h0;
    return base + {1'b0, p.peak} - {1'b0, PEAK_FIRST};
  endfunction

endpackage

/* ctr_result_mem.sv */
// Result word storage with two byte-enabled write ports and a registered read
`timescale 1ns/1ps
module ctr_result_mem #(
  parameter int W = 16,
  parameter int DEPTH = 8,
  parameter int AW = 3
) (
  input wire logic clk, // System clock
  input wire logic rstn, // Async reset, active low
  input wire logic ce, // Clock enable
  input wire logic wa_en, // Port A write
  input wire logic [AW-1:0] wa_addr, // Port A word
  input wire logic [1:0] wa_be, // Port A byte enables
  input wire logic [W-1:0] wa_data, // Port A data
  input wire logic wb_en, // Port B write
  input wire logic [AW-1:0] wb_addr, // Port B word
  input wire logic [1:0] wb_be, // Port B byte enables
  input wire logic [W-1:0] wb_data, // Port B data
  input wire logic rd_en, // Read request
  input wire logic [AW-1:0] rd_addr, // Read word
  output logic [W-1:0] rd_data // Registered read data
);
  localparam int HB = W / 2;
  logic [W-1:0] mem [DEPTH];

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem[i] <= '0;
      end
    end else if (ce) begin
      if (wa_en && wa_be[0]) mem[wa_addr][HB-1:0] <= wa_data[HB-1:0];
      if (wa_en && wa_be[1]) mem[wa_addr][W-1:HB] <= wa_data[W-1:HB];
      // Port B wins on a shared byte
      if (wb_en && wb_be[0]) mem[wb_addr][HB-1:0] <= wb_data[HB-1:0];
      if (wb_en && wb_be[1]) mem[wb_addr][W-1:HB] <= wb_data[W-1:HB];
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rd_data <= '0;
    end else if (ce && rd_en) begin
      rd_data <= mem[rd_addr];
    end
  end
endmodule // ctr_result_mem

/* ctr_ahb_front.sv */
// AHB-Lite address phase decode and data phase tracking
`timescale 1ns/1ps
module ctr_ahb_front
  import ctr_pkg::*;
(
  input wire logic clk, // System clock
  input wire logic rstn, // Async reset, active low
  input wire logic ce, // Clock enable
  input wire logic hsel, // Slave select
  input wire logic [31:0] haddr, // Byte address
  input wire logic [1:0] htrans, // Transfer type
  input wire logic hwrite, // Write when high
  input wire logic hready, // Bus ready
  output ctr_pkg::ctr_acc_s acc_now, // Address phase accepted now
  output ctr_pkg::ctr_acc_s acc_q // Access in its data phase
);
  import ctr_pkg::*;

  always_comb begin
    acc_now.valid = ce && hsel && hready && htrans[HTRANS_ACTIVE_BIT];
    acc_now.write = hwrite;
    acc_now.idx = haddr[ADDR_LSB+IDX_W-1:ADDR_LSB];
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      acc_q <= '0;
    end else if (ce && hready) begin
      acc_q <= acc_now;
    end
  end
endmodule // ctr_ahb_front

/* ctr_tdr_results.sv */
// Cable diagnostic peak result bank behind an AHB-Lite slave
// Functional notes
// - Results count as valid only once the done bit (bit 1 of the control register) reads 1.
// - Index 0x183 reads receive peak location 3 in bits 15:8 and 2 in bits 7:0, reset zero.
// - Index 0x184 reads receive peak location 5 in bits 15:8 and 4 in bits 7:0, reset zero.
// - Index 0x185 reads transmit peak amplitude 2 in bits 14:8 and 1 in bits 6:0, reset zero.
// - Index 0x186 reads transmit peak amplitude 4 in bits 14:8 and 3 in bits 6:0, reset zero.
// - Index 0x187 reads receive amplitude 1 in bits 14:8 and transmit amplitude 5 in 6:0.
// - Bits 15 and 7 of every amplitude register ignore writes and read as zero.
// - Each amplitude half is written with the location byte of the same peak.
// - Indices 0x180 and 0x181 hold transmit peak locations as two bytes each.
//
// Implementation choice: the AHB-Lite slave port.
`timescale 1ns/1ps
module ctr_tdr_results
  import ctr_pkg::*;
(
  input wire logic clk, // System clock, 10 MHz
  input wire logic rstn, // Async reset, active low
  input wire logic ce, // Clock enable, freezes all state
  input wire logic hsel, // AHB select
  input wire logic [31:0] haddr, // AHB address
  input wire logic [1:0] htrans, // AHB transfer type
  input wire logic hwrite, // AHB write
  input wire logic [2:0] hsize, // AHB size, word only
  input wire logic [31:0] hwdata, // AHB write data
  input wire logic hready, // AHB bus ready
  output logic hreadyout, // AHB slave ready
  output logic [31:0] hrdata, // AHB read data
  output logic hresp, // AHB response
  input wire logic eng_peak_we, // Engine peak report strobe
  input wire ctr_pkg::ctr_peak_s eng_peak, // Engine peak report
  input wire logic eng_done, // Engine run finished strobe
  output logic diag_start, // Start pulse to engine
  output logic diag_busy, // Run in progress
  output logic diag_done // Results valid
);
  import ctr_pkg::*;

  ctr_acc_s acc_now;
  ctr_acc_s acc_q;
  logic [RES_W-1:0] mem_rdata;
  logic [RES_W-1:0] ctl_rdata;
  logic rd_from_mem;
  logic ctl_write;
  logic start_req;
  logic peak_ok;
  logic [SLOT_W-1:0] slot;
  logic wa_en;
  logic wb_en;
  logic [MEM_AW-1:0] wa_addr;
  logic [MEM_AW-1:0] wb_addr;
  logic [1:0] half_be;
  logic [RES_W-1:0] wa_data;
  logic [RES_W-1:0] wb_data;

  ctr_ahb_front u_front (
    .clk(clk),
    .rstn(rstn),
    .ce(ce),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hready(hready),
    .acc_now(acc_now),
    .acc_q(acc_q)
  );

  // Frozen clock enable also stalls the bus so nothing is dropped
  assign hreadyout = ce;
  assign hresp = HRESP_OKAY;

  // Only writes to the control register take effect; result words are RO
  assign ctl_write = ce && acc_q.valid && acc_q.write &&
                     (acc_q.idx == IDX_DIAG_CTRL);
  assign start_req = ctl_write && hwdata[START_BIT];

  // Engine reports are mapped so location and amplitude share a peak
  assign slot = ctr_slot(eng_peak);
  assign peak_ok = (eng_peak.peak >= PEAK_FIRST) &&
                   (eng_peak.peak <= PEAK_LAST);
  // Reports outside a run are dropped to keep old results stable
  assign wa_en = eng_peak_we && peak_ok && diag_busy;
  assign wb_en = wa_en && (slot < AMP_SLOTS);
  assign half_be = {slot[0], ~slot[0]};
  assign wa_addr = LOC_BASE + slot[SLOT_W-1:1];
  assign wb_addr = AMP_BASE + slot[SLOT_W-1:1];
  assign wa_data = {eng_peak.loc, eng_peak.loc};
  // Spare bits forced low on the way in
  assign wb_data = {1'b0, eng_peak.amp, 1'b0, eng_peak.amp} &
                   AMP_MASK;

  ctr_result_mem #(
    .W(RES_W),
    .DEPTH(RES_WORDS),
    .AW(MEM_AW)
  ) u_mem (
    .clk(clk),
    .rstn(rstn),
    .ce(ce),
    .wa_en(wa_en),
    .wa_addr(wa_addr),
    .wa_be(half_be),
    .wa_data(wa_data),
    .wb_en(wb_en),
    .wb_addr(wb_addr),
    .wb_be(half_be),
    .wb_data(wb_data),
    .rd_en(acc_now.valid && !acc_now.write),
    .rd_addr(ctr_mem_addr(acc_now.idx)),
    .rd_data(mem_rdata)
  );

  // Run state; a report of done in the same cycle as a start still lands
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      diag_busy <= 1'b0;
    end else if (ce) begin
      if (start_req) diag_busy <= 1'b1;
      else if (eng_done) diag_busy <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      diag_done <= 1'b0;
    end else if (ce) begin
      if (eng_done && (diag_busy || start_req)) diag_done <= 1'b1;
      else if (start_req) diag_done <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      diag_start <= 1'b0;
    end else if (ce) begin
      diag_start <= start_req;
    end
  end

  // Read data captured at the address phase edge
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ctl_rdata <= RESET_WORD;
      rd_from_mem <= 1'b0;
    end else if (ce && acc_now.valid && !acc_now.write) begin
      rd_from_mem <= ctr_in_results(acc_now.idx);
      ctl_rdata <= RESET_WORD;
      if (acc_now.idx == IDX_DIAG_CTRL) begin
        ctl_rdata[DONE_BIT] <= diag_done;
        ctl_rdata[BUSY_BIT] <= diag_busy;
      end
    end
  end

  // Unmapped reads return zero; upper half always zero
  assign hrdata = {RESET_WORD, rd_from_mem ? mem_rdata : ctl_rdata};

endmodule // ctr_tdr_results

/* ctr_tdr_results_monitor.sv */
// Port assertions for the cable diagnostic result bank
`timescale 1ns/1ps
module ctr_tdr_results_monitor
  import ctr_pkg::*;
(
  input wire logic clk, // Clock
  input wire logic rstn, // Reset, active low
  input wire logic ce, // Clock enable
  input wire logic hsel, // Select
  input wire logic [31:0] haddr, // Address
  input wire logic [1:0] htrans, // Transfer type
  input wire logic hwrite, // Write
  input wire logic [31:0] hwdata, // Write data
  input wire logic hready, // Bus ready
  input wire logic hreadyout, // Slave ready
  input wire logic [31:0] hrdata, // Read data
  input wire logic eng_done, // Run finished
  input wire logic diag_start, // Start pulse
  input wire logic diag_busy, // Running
  input wire logic diag_done // Results valid
);
  logic take;
  logic [IDX_W-1:0] idx;
  logic amp_q;
  logic ctl_q;
  assign take = hsel && htrans[1] && hready && ce;
  assign idx = haddr[11:2];
  // Data phase follows the taken address phase; frozen with ce
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      amp_q <= 1'b0;
      ctl_q <= 1'b0;
    end else if (ce) begin
      amp_q <= take && !hwrite && idx >= IDX_TX_PEAK_AMP_2_1
        && idx <= IDX_RX_AMP1_TX_AMP5;
      ctl_q <= take && hwrite && idx == IDX_DIAG_CTRL;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  a_ready_tracks_ce: assert property (hreadyout == ce)
    else $error("hreadyout differs from clock enable");
  a_upper_half_zero: assert property (hrdata[31:16] == 16'h0000)
    else $error("read data upper half not zero");
  a_amp_reserved_zero: assert property (
    amp_q |-> hrdata[15] == 1'b0 && hrdata[7] == 1'b0)
    else $error("amplitude spare bit read as one");
  a_done_on_end: assert property (
    eng_done && diag_busy && ce |=> diag_done)
    else $error("done not set after run end");
  a_start_sets_busy: assert property (diag_start |-> diag_busy)
    else $error("start pulse without busy");
  a_done_until_start: assert property (
    $fell(diag_done) |-> diag_start)
    else $error("done dropped without a new start");
  a_busy_ends_run: assert property (
    $fell(diag_busy) |-> $past(eng_done))
    else $error("busy dropped without run end");
  a_start_from_write: assert property (
    diag_start |-> $past(ctl_q && hwdata[0] && ce))
    else $error("start pulse without control write");
  a_freeze_holds_state: assert property (
    !ce |=> $stable(hrdata) && $stable(diag_busy) && $stable(diag_done)
      && $stable(diag_start))
    else $error("state moved while clock enable low");
endmodule // ctr_tdr_results_monitor

/* tb.sv */
// Self-checking bench for the cable diagnostic result bank
`timescale 1ns/1ps
module tb;
  import ctr_pkg::*;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = '0;
  logic [1:0] htrans = 2'b00;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = '0;
  logic eng_peak_we = 1'b0;
  ctr_peak_s eng_peak = '0;
  logic eng_done = 1'b0;
  logic ce = 1'b1;
  logic hreadyout, hresp, diag_start, diag_busy, diag_done;
  logic [31:0] hrdata, rd;
  logic [7:0] locs [10] = '{default: '0};
  logic [6:0] amps [10] = '{default: '0};
  int fails = 0;
  int num_checks = 0;
  int cycles = 0;

  initial forever #50 clk = ~clk;

  ctr_tdr_results ctr_tdr_results_inst (
    .clk(clk), .rstn(rstn), .ce(ce), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
    .hresp(hresp), .eng_peak_we(eng_peak_we), .eng_peak(eng_peak),
    .eng_done(eng_done), .diag_start(diag_start), .diag_busy(diag_busy),
    .diag_done(diag_done));

  function automatic logic [31:0] exp_word(input int k);
    if (k < 5)
      return {16'h0000, locs[2*k+1], locs[2*k]};
    return {16'h0000, 1'b0, amps[2*k-9], 1'b0, amps[2*k-10]};
  endfunction

  task automatic chk(input string what, input logic [31:0] exp,
      input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic bus(input logic w, input logic [9:0] idx,
      input logic [31:0] wd);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    haddr <= {20'h00000, idx, 2'b00};
    hwrite <= w;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic check_all();
    for (int k = 0; k < 8; k++) begin
      bus(1'b0, IDX_TX_LOC_2_1 + 10'(k), 32'h0);
      chk($sformatf("word %0d", k), exp_word(k), rd);
      chk("hresp", 32'(HRESP_OKAY), 32'(hresp));
    end
  endtask

  // Model follows only peaks the engine is allowed to store
  task automatic report(input logic rx, input logic [2:0] n, input logic upd);
    int s;
    eng_peak_we <= 1'b1;
    eng_peak <= {rx, n, 8'($urandom), 7'($urandom)};
    @(posedge clk);
    s = rx ? 4 + n : n - 1;
    if (upd) begin
      locs[s] = eng_peak.loc;
      if (s < 6)
        amps[s] = eng_peak.amp;
    end
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      fails++;
      conclude();
    end
  end

  initial begin
    void'($urandom(32'h5ac72578));
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    check_all();
    bus(1'b0, 10'h3ff, 32'h0);
    chk("unmapped", 32'h0, rd);
    report(1'b0, 3'h2, 1'b0);
    eng_peak_we <= 1'b0;
    check_all();
    // Second run reports a random subset; the rest must keep old values
    for (int run = 0; run < 2; run++) begin
      bus(1'b1, IDX_DIAG_CTRL, 32'h1);
      bus(1'b0, IDX_DIAG_CTRL, 32'h0);
      chk("control busy", 32'h4, rd);
      if (run == 1) begin
        // Engine events during a freeze must be lost
        ce <= 1'b0;
        eng_done <= 1'b1;
        report(1'b0, 3'h1, 1'b0);
        ce <= 1'b1;
        eng_done <= 1'b0;
        eng_peak_we <= 1'b0;
        bus(1'b0, IDX_DIAG_CTRL, 32'h0);
        chk("frozen busy", 32'h4, rd);
      end
      for (int p = 0; p < 10; p++)
        if (run == 0 || $urandom_range(1))
          report(p >= 5, 3'(p % 5 + 1), 1'b1);
      report(1'b1, 3'h6, 1'b0);
      report(1'b0, 3'h0, 1'b0);
      eng_peak_we <= 1'b0;
      eng_done <= 1'b1;
      @(posedge clk);
      eng_done <= 1'b0;
      bus(1'b0, IDX_DIAG_CTRL, 32'h0);
      chk("control done", 32'h2, rd);
      chk("done pin", 32'h1, 32'(diag_done));
      check_all();
    end
    // Control write without the start bit leaves the results valid
    bus(1'b1, IDX_DIAG_CTRL, 32'h0);
    bus(1'b0, IDX_DIAG_CTRL, 32'h0);
    chk("no start", 32'h2, rd);
    for (int k = 0; k < 8; k++)
      bus(1'b1, IDX_TX_LOC_2_1 + 10'(k), 32'hffffffff);
    report(1'b1, 3'h1, 1'b0);
    eng_peak_we <= 1'b0;
    check_all();
    rstn <= 1'b0;
    @(posedge clk);
    rstn <= 1'b1;
    locs = '{default: '0};
    amps = '{default: '0};
    check_all();
    bus(1'b0, IDX_DIAG_CTRL, 32'h0);
    chk("control reset", 32'h0, rd);
    conclude();
  end
endmodule // tb

bind ctr_tdr_results ctr_tdr_results_monitor ctr_tdr_results_monitor_inst (
  .clk(clk), .rstn(rstn), .ce(ce), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
  .hreadyout(hreadyout), .hrdata(hrdata), .eng_done(eng_done),
  .diag_start(diag_start), .diag_busy(diag_busy), .diag_done(diag_done));
